// File: hdl/fisp_map.svh
`ifndef FISP_MAP_SVH
`define FISP_MAP_SVH
// register byte offsets
`define FISP_OFS_ADDR_HI 12'h000
`define FISP_OFS_ADDR_LO 12'h004
`define FISP_OFS_RDATA 12'h008
`define FISP_OFS_WDATA 12'h00c
`define FISP_OFS_TIMING 12'h010
`define FISP_OFS_CTRL 12'h014
`define FISP_OFS_STATUS 12'h018
// reset values
`define FISP_RST_ADDR 8'h00
`define FISP_RST_TIMING 8'h7b
`define FISP_TIMING_MASK 8'h7f
// cycles the sequencer waits for the boot bit after reset
`define FISP_BOOT_SETTLE 3'h7
// memory map
`define FISP_ROM_BYTES 1024
`define FISP_FLASH_START 16'h0000
`define FISP_OPT_ADDR 16'h3fff
`define FISP_OPT_ALIAS 16'hffff
// control fields
`define FISP_CTRL_OP_LSB 0
`define FISP_CTRL_LEAVE_BIT 6
`define FISP_CTRL_START_BIT 7
// status fields
`define FISP_ST_ROM_BIT 0
`define FISP_ST_BUSY_BIT 1
`define FISP_ST_ERR_BIT 2
`endif

// File: hdl/fisp_pkg.sv
package fisp_pkg;
  typedef enum logic [1:0] {
    FISP_OP_READ,
    FISP_OP_WRITE,
    FISP_OP_PAGE_ERASE,
    FISP_OP_MASS_ERASE
  } fisp_op_t;
  typedef enum logic [1:0] {
    FISP_BOOT_WAIT,
    FISP_IDLE,
    FISP_RUN
  } fisp_state_t;
endpackage

// File: hdl/fisp_boot_rom.sv
`timescale 1ns/10ps
module fisp_boot_rom #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // factory load port
  input wire logic i_load_en,
  input wire logic [AW-1:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  // fetch port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rd_d;

  initial
  begin
    if (DEPTH != (1 << AW))
      $error("boot rom depth must equal 2**AW");
  end

  // contents are filled once at the factory, then only read
  always_comb
  begin
    rd_d = mem[i_rd_addr];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_load_en)
      mem[i_load_addr] <= i_load_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= rd_d;
  end
endmodule

// File: hdl/fisp_top.sv
// Function
// R01 - factory boot ROM of 1k bytes
// R02 - boot bit 0 starts in boot ROM
// R03 - boot bit 1 starts flash at 0000
// R04 - loader in ROM watches serial port
// R05 - programmer sets boot bit, then resets
// R06 - user programming routine lives in flash
// R07 - six registers, control hidden from user; this design adds a seventh, status
// R08 - high and low bytes form address
// R09 - page erase uses page first address
// R10 - mass erase uses address 0000
// R11 - option byte read uses address FFFF
// R12 - FFFF aliases option byte at 3FFF
// R13 - address registers reset to 00
// R14 - flash or ROM code writes registers
// R15 - software holds address during operation
// R16 - read data register captures read byte
// R17 - write data register holds write byte
// R18 - software holds write data until done
// R19 - software loads timing before write/erase
// R20 - timing resets to 10 MHz code
// R21 - sample at start, stall until done
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "fisp_map.svh"
module fisp_top #(
  parameter int ROM_BYTES = `FISP_ROM_BYTES,
  parameter int ROM_AW = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [2:0] i_pprot,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // nonvolatile option bits
  input wire logic i_boot_src,
  input wire logic i_secured,
  // core control
  output logic o_exec_rom,
  output logic o_serial_watch,
  output logic o_core_restart,
  output logic o_cpu_stall,
  // boot rom ports
  input wire logic i_rom_load_en,
  input wire logic [ROM_AW-1:0] i_rom_load_addr,
  input wire logic [7:0] i_rom_load_data,
  input wire logic [ROM_AW-1:0] i_rom_rd_addr,
  output logic [7:0] o_rom_rdata,
  // flash array
  output logic o_flash_req,
  output fisp_pkg::fisp_op_t o_flash_op,
  output logic [15:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic [7:0] o_flash_timing,
  input wire logic i_flash_done,
  input wire logic [7:0] i_flash_rdata
);
  import fisp_pkg::*;

  initial
  begin
    if (ROM_BYTES != 1024 || ROM_AW != 10)
      $error("boot rom must be 1k bytes");
  end

  function automatic logic [15:0] eff_addr(input logic [15:0] a);
    eff_addr = (a == `FISP_OPT_ALIAS) ? `FISP_OPT_ADDR : a;
  endfunction

  // pin synchronisers; a change counts once stages two and three agree
  logic [2:0] boot_sync_q, boot_sync_d;
  logic [2:0] sec_sync_q, sec_sync_d;
  logic boot_bit_q, boot_bit_d;
  logic sec_bit_q, sec_bit_d;

  // sequencer
  fisp_state_t state_q, state_d;
  logic [2:0] settle_q, settle_d;
  logic exec_rom_q, exec_rom_d;
  logic serial_q, serial_d;
  logic restart_q, restart_d;
  logic stall_q, stall_d;

  // software registers
  logic [7:0] addr_hi_q, addr_hi_d;
  logic [7:0] addr_lo_q, addr_lo_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] timing_q, timing_d;
  logic err_q, err_d;

  // apb response
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // flash request
  logic req_q, req_d;
  fisp_op_t op_q, op_d;
  logic [15:0] faddr_q, faddr_d;
  logic [7:0] fwdata_q, fwdata_d;
  logic [7:0] ftiming_q, ftiming_d;

  // decode
  logic acc_phase;
  logic wr_fire;
  logic start_fire;
  logic leave_fire;
  logic refuse;
  logic sec_block;
  logic [15:0] sw_addr;
  fisp_op_t new_op;

  always_comb
  begin
    boot_sync_d = {boot_sync_q[1:0], i_boot_src};
    sec_sync_d = {sec_sync_q[1:0], i_secured};
    boot_bit_d = boot_bit_q;
    sec_bit_d = sec_bit_q;
    if (boot_sync_q[1] == boot_sync_q[2])
      boot_bit_d = boot_sync_q[2];
    if (sec_sync_q[1] == sec_sync_q[2])
      sec_bit_d = sec_sync_q[2];
  end

  // erased boot bit reads 0, so reset assumes boot rom
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      boot_sync_q <= 3'h0;
      sec_sync_q <= 3'h0;
      boot_bit_q <= 1'b0;
      sec_bit_q <= 1'b0;
    end
    else
    begin
      boot_sync_q <= boot_sync_d;
      sec_sync_q <= sec_sync_d;
      boot_bit_q <= boot_bit_d;
      sec_bit_q <= sec_bit_d;
    end
  end

  always_comb
  begin
    sw_addr = {addr_hi_q, addr_lo_q}; // R08
    new_op = fisp_op_t'(i_pwdata[`FISP_CTRL_OP_LSB +: 2]);
    acc_phase = i_psel & i_penable & ~pready_q;
    wr_fire = i_psel & i_penable & pready_q & i_pwrite & ~pslverr_q &
      i_pstrb[0];
    // secured parts read the option byte only through its alias
    sec_block = sec_bit_q & (new_op == FISP_OP_READ) &
      (sw_addr == `FISP_OPT_ADDR); // R12
    start_fire = wr_fire & (i_paddr == `FISP_OFS_CTRL) &
      i_pwdata[`FISP_CTRL_START_BIT];
    leave_fire = wr_fire & (i_paddr == `FISP_OFS_CTRL) &
      i_pwdata[`FISP_CTRL_LEAVE_BIT] & ~i_pwdata[`FISP_CTRL_START_BIT];
    case (i_paddr)
      `FISP_OFS_ADDR_HI, `FISP_OFS_ADDR_LO, `FISP_OFS_WDATA,
      `FISP_OFS_TIMING, `FISP_OFS_STATUS:
        refuse = 1'b0;
      `FISP_OFS_RDATA:
        refuse = i_pwrite;
      // control: write only, boot rom code only, idle only
      `FISP_OFS_CTRL:
        refuse = ~i_pwrite | ~exec_rom_q | (state_q != FISP_IDLE) |
          (i_pwdata[`FISP_CTRL_START_BIT] & sec_block); // R07
      default:
        refuse = 1'b1;
    endcase
  end

  always_comb
  begin
    addr_hi_d = addr_hi_q;
    addr_lo_d = addr_lo_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    timing_d = timing_q;
    err_d = err_q;
    if (wr_fire)
    begin
      case (i_paddr)
        `FISP_OFS_ADDR_HI:
          addr_hi_d = i_pwdata[7:0]; // R14
        `FISP_OFS_ADDR_LO:
          addr_lo_d = i_pwdata[7:0]; // R14
        `FISP_OFS_WDATA:
          wdata_d = i_pwdata[7:0]; // R17
        // top bit of the timing code is read only
        `FISP_OFS_TIMING:
          timing_d = i_pwdata[7:0] & `FISP_TIMING_MASK;
        `FISP_OFS_STATUS:
          err_d = err_q & ~i_pwdata[`FISP_ST_ERR_BIT];
        default:
          err_d = err_q;
      endcase
    end
    if (state_q == FISP_RUN && i_flash_done && op_q == FISP_OP_READ)
      rdata_d = i_flash_rdata; // R16
    // a refusal in the cycle of a clear still sets the flag
    if (i_psel && i_penable && pready_q && pslverr_q)
      err_d = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      addr_hi_q <= `FISP_RST_ADDR; // R13
      addr_lo_q <= `FISP_RST_ADDR; // R13
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      timing_q <= `FISP_RST_TIMING; // R20
      err_q <= 1'b0;
    end
    else
    begin
      addr_hi_q <= addr_hi_d;
      addr_lo_q <= addr_lo_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      timing_q <= timing_d;
      err_q <= err_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    settle_d = settle_q;
    exec_rom_d = exec_rom_q;
    restart_d = 1'b0;
    req_d = req_q;
    op_d = op_q;
    faddr_d = faddr_q;
    fwdata_d = fwdata_q;
    ftiming_d = ftiming_q;
    case (state_q)
      // the boot bit must clear its synchroniser before it is used
      FISP_BOOT_WAIT:
      begin
        if (settle_q == `FISP_BOOT_SETTLE)
        begin
          exec_rom_d = ~boot_bit_q; // R02 R03
          state_d = FISP_IDLE;
        end
        else
          settle_d = settle_q + 3'h1;
      end
      FISP_IDLE:
      begin
        if (start_fire)
        begin
          state_d = FISP_RUN;
          req_d = 1'b1;
          op_d = new_op; // R21
          faddr_d = (new_op == FISP_OP_READ) ? eff_addr(sw_addr) : sw_addr;
          fwdata_d = wdata_q; // R21
          ftiming_d = timing_q; // R21
        end
        else if (leave_fire)
        begin
          state_d = FISP_BOOT_WAIT;
          settle_d = 3'h0;
          restart_d = 1'b1;
        end
      end
      FISP_RUN:
      begin
        if (i_flash_done)
        begin
          state_d = FISP_IDLE;
          req_d = 1'b0;
        end
      end
      default:
        state_d = FISP_BOOT_WAIT;
    endcase
    // core is held while the flash is busy or the boot choice pends
    stall_d = (state_d != FISP_IDLE); // R21
    serial_d = exec_rom_d; // R04
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= FISP_BOOT_WAIT;
      settle_q <= 3'h0;
      exec_rom_q <= 1'b1;
      serial_q <= 1'b1;
      restart_q <= 1'b0;
      stall_q <= 1'b1;
      req_q <= 1'b0;
      op_q <= FISP_OP_READ;
      faddr_q <= `FISP_FLASH_START;
      fwdata_q <= 8'h00;
      ftiming_q <= `FISP_RST_TIMING;
    end
    else
    begin
      state_q <= state_d;
      settle_q <= settle_d;
      exec_rom_q <= exec_rom_d;
      serial_q <= serial_d;
      restart_q <= restart_d;
      stall_q <= stall_d;
      req_q <= req_d;
      op_q <= op_d;
      faddr_q <= faddr_d;
      fwdata_q <= fwdata_d;
      ftiming_q <= ftiming_d;
    end
  end

  // one wait state; read data are settled when ready rises
  always_comb
  begin
    pready_d = acc_phase;
    pslverr_d = acc_phase & refuse;
    prdata_d = prdata_q;
    if (acc_phase && !i_pwrite)
    begin
      prdata_d = 32'h0;
      case (i_paddr)
        `FISP_OFS_ADDR_HI:
          prdata_d[7:0] = addr_hi_q;
        `FISP_OFS_ADDR_LO:
          prdata_d[7:0] = addr_lo_q;
        `FISP_OFS_RDATA:
          prdata_d[7:0] = rdata_q;
        `FISP_OFS_WDATA:
          prdata_d[7:0] = wdata_q;
        `FISP_OFS_TIMING:
          prdata_d[7:0] = timing_q;
        `FISP_OFS_STATUS:
        begin
          prdata_d[`FISP_ST_ROM_BIT] = exec_rom_q;
          prdata_d[`FISP_ST_BUSY_BIT] = (state_q == FISP_RUN);
          prdata_d[`FISP_ST_ERR_BIT] = err_q;
        end
        default:
          prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;
  assign o_exec_rom = exec_rom_q;
  assign o_serial_watch = serial_q;
  assign o_core_restart = restart_q;
  assign o_cpu_stall = stall_q;
  assign o_flash_req = req_q;
  assign o_flash_op = op_q;
  assign o_flash_addr = faddr_q;
  assign o_flash_wdata = fwdata_q;
  assign o_flash_timing = ftiming_q;

  fisp_boot_rom #(
    .DEPTH(ROM_BYTES),
    .AW(ROM_AW)
  ) i_fisp_boot_rom ( // R01
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load_en(i_rom_load_en),
    .i_load_addr(i_rom_load_addr),
    .i_load_data(i_rom_load_data),
    .i_rd_addr(i_rom_rd_addr),
    .o_rd_data(o_rom_rdata)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_boot_rom;
    (state_q == FISP_BOOT_WAIT && state_d == FISP_IDLE && !boot_bit_q)
      |=> exec_rom_q;
  endproperty
  a_boot_rom: assert property (p_boot_rom) // R02
    else $error("boot bit 0 did not select boot rom");

  property p_boot_flash;
    (state_q == FISP_BOOT_WAIT && state_d == FISP_IDLE && boot_bit_q)
      |=> !exec_rom_q;
  endproperty
  a_boot_flash: assert property (p_boot_flash) // R03
    else $error("boot bit 1 did not select flash");

  property p_watch;
    serial_q == exec_rom_q;
  endproperty
  a_watch: assert property (p_watch) // R04
    else $error("serial watch differs from boot rom execution");

  property p_ctrl_hidden;
    (acc_phase && i_paddr == `FISP_OFS_CTRL && !exec_rom_q) |=> pslverr_q;
  endproperty
  a_ctrl_hidden: assert property (p_ctrl_hidden) // R07
    else $error("control reached from flash code");

  property p_alias;
    (start_fire && state_q == FISP_IDLE && new_op == FISP_OP_READ &&
      sw_addr == `FISP_OPT_ALIAS) |=> faddr_q == `FISP_OPT_ADDR;
  endproperty
  a_alias: assert property (p_alias) // R12
    else $error("option alias not mapped");

  property p_read_cap;
    (state_q == FISP_RUN && i_flash_done && op_q == FISP_OP_READ)
      |=> rdata_q == $past(i_flash_rdata);
  endproperty
  a_read_cap: assert property (p_read_cap) // R16
    else $error("read byte not captured");

  property p_sample;
    (start_fire && state_q == FISP_IDLE) |=> req_q &&
      fwdata_q == $past(wdata_q) && ftiming_q == $past(timing_q);
  endproperty
  a_sample: assert property (p_sample) // R21
    else $error("operation fields not sampled at start");

  property p_stall;
    stall_q == (state_q != FISP_IDLE);
  endproperty
  a_stall: assert property (p_stall) // R21
    else $error("core not stalled while busy");

  c_read: cover property (start_fire && new_op == FISP_OP_READ);
  c_mass: cover property (start_fire && new_op == FISP_OP_MASS_ERASE);
  c_leave: cover property (leave_fire);
endmodule

// File: test/fisp_flash_model.sv
`timescale 1ns/10ps
module fisp_flash_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // array side
  input wire logic i_req,
  output logic o_done,
  output logic [7:0] o_rdata
);
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      o_done <= 1'b0;
    else
      o_done <= i_req & ~o_done;
  // data only valid with done
  assign o_rdata = o_done ? 8'h5a : 8'ha5;
endmodule

// File: test/test_fisp_top.sv
`timescale 1ns/10ps
`include "fisp_map.svh"
module test_fisp_top;
  import fisp_pkg::*;
  logic i_clk=0, i_rst_b=0, i_psel=0, i_penable=0, i_pwrite=0;
  logic i_boot_src=0, i_secured=0, i_rom_load_en=0, i_flash_done;
  logic o_pready, o_pslverr, o_exec_rom, o_serial_watch, o_core_restart;
  logic o_cpu_stall, o_flash_req;
  logic [11:0] i_paddr=0;
  logic [31:0] i_pwdata=0, o_prdata, rd;
  logic [3:0] i_pstrb=4'hf;
  logic [2:0] i_pprot=0;
  logic [9:0] i_rom_load_addr=0, i_rom_rd_addr=0;
  logic [7:0] i_rom_load_data=0, i_flash_rdata, o_rom_rdata, cap_w;
  logic [7:0] o_flash_wdata, o_flash_timing;
  logic [15:0] o_flash_addr, cap_a;
  logic [1:0] cap_o;
  logic [7:0] cap_t;
  logic cap_s=0, err, restart_seen=0;
  fisp_op_t o_flash_op;
  int error_cnt=0, n_checks=0;
  always #4 i_clk = ~i_clk;
  fisp_top i_fisp_top (.*);
  fisp_flash_model i_fisp_flash_model (.i_clk, .i_rst_b,
    .i_req(o_flash_req), .o_done(i_flash_done), .o_rdata(i_flash_rdata));
  always @(posedge i_clk)
  begin
    if (o_flash_req === 1'b1)
    begin
      {cap_a, cap_w, cap_o} <= {o_flash_addr, o_flash_wdata, o_flash_op};
      {cap_t, cap_s} <= {o_flash_timing, o_cpu_stall};
    end
    if (o_core_restart === 1'b1)
      restart_seen <= 1'b1;
  end
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge i_clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic cmp(input string s, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wait_idle;
    do @(posedge i_clk); while (o_cpu_stall !== 1'b0);
  endtask
  task t_reset_vals;
    apb(0, `FISP_OFS_ADDR_HI, 0);
    cmp("addr_hi", 16'h0000, rd[7:0]);
    apb(0, `FISP_OFS_ADDR_LO, 0);
    cmp("addr_lo", 16'h0000, rd[7:0]);
    apb(0, `FISP_OFS_TIMING, 0);
    cmp("timing", 16'h007b, rd[7:0]);
  endtask
  task t_boot;
    wait_idle;
    cmp("exec_rom", 16'h0001, o_exec_rom);
    cmp("serial_watch", 16'h0001, o_serial_watch);
    i_rom_load_en <= 1'b1;
    i_rom_load_addr <= 10'h005;
    i_rom_load_data <= 8'h3c;
    @(posedge i_clk);
    i_rom_load_en <= 1'b0;
    i_rom_rd_addr <= 10'h005;
    repeat (2) @(posedge i_clk);
    cmp("rom_byte", 16'h003c, o_rom_rdata);
  endtask
  task t_write_op;
    apb(1, `FISP_OFS_ADDR_HI, 32'h12);
    apb(1, `FISP_OFS_ADDR_LO, 32'h34);
    apb(1, `FISP_OFS_WDATA, 32'ha5);
    apb(0, `FISP_OFS_ADDR_HI, 0);
    cmp("addr_hi", 16'h0012, rd[7:0]);
    apb(1, `FISP_OFS_CTRL, 32'h81);
    cmp("start_err", 16'h0000, err);
    wait_idle;
    apb(0, `FISP_OFS_ADDR_LO, 0);
    cmp("addr_lo", 16'h0034, rd[7:0]);
    apb(0, `FISP_OFS_WDATA, 0);
    cmp("wdata", 16'h00a5, rd[7:0]);
    cmp("flash_addr", 16'h1234, cap_a);
    cmp("flash_wdata", 16'h00a5, cap_w);
    cmp("flash_op", 16'h0001, cap_o);
    cmp("flash_timing", 16'h007b, cap_t);
    cmp("stall", 16'h0001, cap_s);
  endtask
  task t_read_op;
    i_secured <= 1'b1;
    apb(1, `FISP_OFS_ADDR_HI, 32'hff);
    apb(1, `FISP_OFS_ADDR_LO, 32'hff);
    apb(1, `FISP_OFS_CTRL, 32'h80);
    wait_idle;
    cmp("alias_addr", 16'h3fff, cap_a);
    apb(0, `FISP_OFS_RDATA, 0);
    cmp("rdata", 16'h005a, rd[7:0]);
    apb(1, `FISP_OFS_ADDR_HI, 32'h3f);
    apb(1, `FISP_OFS_CTRL, 32'h80);
    cmp("secured_direct", 16'h0001, err);
    apb(0, `FISP_OFS_STATUS, 0);
    cmp("err_flag", 16'h0001, rd[`FISP_ST_ERR_BIT]);
    apb(1, `FISP_OFS_STATUS, 32'h4);
    apb(0, `FISP_OFS_STATUS, 0);
    cmp("err_clear", 16'h0000, rd[`FISP_ST_ERR_BIT]);
    i_secured <= 1'b0;
  endtask
  task t_erase;
    apb(1, `FISP_OFS_ADDR_HI, 32'h02);
    apb(1, `FISP_OFS_ADDR_LO, 32'h00);
    apb(1, `FISP_OFS_CTRL, 32'h82);
    wait_idle;
    cmp("page_op", 16'h0002, cap_o);
    cmp("page_addr", 16'h0200, cap_a);
    apb(1, `FISP_OFS_ADDR_HI, 32'h00);
    apb(1, `FISP_OFS_CTRL, 32'h83);
    wait_idle;
    cmp("mass_op", 16'h0003, cap_o);
    cmp("mass_addr", 16'h0000, cap_a);
  endtask
  task t_timing;
    apb(1, `FISP_OFS_TIMING, 32'h4f);
    apb(0, `FISP_OFS_TIMING, 0);
    cmp("timing", 16'h004f, rd[7:0]);
    apb(1, `FISP_OFS_CTRL, 32'h81);
    wait_idle;
    cmp("flash_timing", 16'h004f, cap_t);
  endtask
  task t_leave;
    i_boot_src <= 1'b1;
    apb(1, `FISP_OFS_CTRL, 32'h40);
    wait_idle;
    cmp("restart", 16'h0001, restart_seen);
    cmp("exec_rom", 16'h0000, o_exec_rom);
    cmp("serial_watch", 16'h0000, o_serial_watch);
    apb(1, `FISP_OFS_ADDR_LO, 32'h77);
    apb(0, `FISP_OFS_ADDR_LO, 0);
    cmp("addr_lo", 16'h0077, rd[7:0]);
    apb(1, `FISP_OFS_CTRL, 32'h81);
    cmp("ctrl_hidden", 16'h0001, err);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset_vals;
    t_boot;
    t_write_op;
    t_read_op;
    t_erase;
    t_timing;
    t_leave;
    give_verdict;
  end
  initial
  begin
    #50us;
    error_cnt++;
    give_verdict;
  end
endmodule
